// [ioh_top.sv]
// interrupt output configuration register with hold-off timer
module ioh_top #(
  parameter int TICK_CYCLES = ioh_pkg::IOH_TICK_CYCLES
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  input wire logic source_irq_in,
  input wire logic power_event_in,
  output logic irq_pin_out,
  output logic irq_pin_oe_out
);
  import ioh_pkg::*;
  logic [7:0] interval_reg;
  logic [7:0] interval_next;
  logic enable_reg;
  logic enable_next;
  logic polarity_reg;
  logic polarity_next;
  logic type_reg;
  logic type_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  ioh_state_e state_reg;
  ioh_state_e state_next;
  logic assert_reg;
  logic assert_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic cfg_wr;
  logic restart;
  logic zero_wr;
  logic tick;
  logic tick_clear;
  logic [7:0] wr_interval;

  assign cfg_wr = reg_wr_in && (reg_addr_in == IOH_CFG_OFFSET);
  assign wr_interval = reg_wdata_in[IOH_INTERVAL_HI:IOH_INTERVAL_LO];
  assign restart = cfg_wr && reg_wdata_in[IOH_RESTART_BIT];
  assign zero_wr = cfg_wr && (wr_interval == 8'h00);
  // tick phase realigned on restart so an interval is never short by a partial unit
  assign tick_clear = restart || (state_reg == IOH_IDLE);

  ioh_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(tick_clear),
    .tick_out(tick)
  );

  // configuration fields
  always_comb begin
    interval_next = interval_reg;
    enable_next = enable_reg;
    polarity_next = polarity_reg;
    type_next = type_reg;
    if (cfg_wr) begin
      interval_next = wr_interval;
      enable_next = reg_wdata_in[IOH_ENABLE_BIT];
      polarity_next = reg_wdata_in[IOH_POLARITY_BIT];
      type_next = reg_wdata_in[IOH_TYPE_BIT];
    end
  end

  // hold-off state machine
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    assert_next = assert_reg;
    case (state_reg)
      IOH_IDLE: begin
        assert_next = source_irq_in;
        // assertion dropping with the source starts a hold-off if one is set, whatever enable is
        if (assert_reg && !source_irq_in && interval_reg != 8'h00) begin
          state_next = IOH_HOLD;
          count_next = 8'h00;
        end
      end
      IOH_HOLD: begin
        assert_next = 1'b0;
        if (tick) begin
          count_next = count_reg + 8'h01;
        end
        if (count_reg >= interval_reg) begin
          state_next = IOH_IDLE;
          count_next = 8'h00;
        end
      end
      default: begin
        state_next = IOH_IDLE;
      end
    endcase
    if (restart && !zero_wr) begin
      state_next = IOH_HOLD;
      count_next = 8'h00;
      assert_next = 1'b0;
    end
    if (zero_wr) begin
      state_next = IOH_IDLE;
      count_next = 8'h00;
    end
  end

  // readback
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd_in) begin
      if (reg_addr_in == IOH_CFG_OFFSET) begin
        rdata_next = 32'h0000_0000;
        rdata_next[IOH_INTERVAL_HI:IOH_INTERVAL_LO] = interval_reg;
        rdata_next[IOH_ACTIVE_BIT] = (state_reg == IOH_HOLD);
        rdata_next[IOH_MASTER_BIT] = source_irq_in || power_event_in;
        rdata_next[IOH_ENABLE_BIT] = enable_reg;
        rdata_next[IOH_POLARITY_BIT] = polarity_reg;
        rdata_next[IOH_TYPE_BIT] = type_reg;
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      interval_reg <= IOH_INTERVAL_RESET;
      enable_reg <= 1'b0;
      polarity_reg <= 1'b0;
      type_reg <= 1'b0;
      state_reg <= IOH_IDLE;
      count_reg <= 8'h00;
      assert_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      interval_reg <= interval_next;
      enable_reg <= enable_next;
      polarity_reg <= polarity_next;
      type_reg <= type_next;
      state_reg <= state_next;
      count_reg <= count_next;
      assert_reg <= assert_next;
      rdata_reg <= rdata_next;
    end
  end

  logic drive;
  // power event skips the hold-off; enable gates only the pin
  assign drive = enable_reg && (assert_reg || power_event_in);

  ioh_pin u_pin (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .assert_in(drive),
    .pin_polarity_in(polarity_reg),
    .push_pull_in(type_reg),
    .pin_out(irq_pin_out),
    .pin_oe_out(irq_pin_oe_out)
  );

  assign reg_rdata_out = rdata_reg;
endmodule

// [ioh_pkg.sv]
// package for interrupt output hold-off block: offsets, fields, timing
package ioh_pkg;
  localparam logic [7:0] IOH_CFG_OFFSET = 8'h54;
  localparam int IOH_INTERVAL_HI = 31;
  localparam int IOH_INTERVAL_LO = 24;
  localparam int IOH_RESTART_BIT = 14;
  localparam int IOH_ACTIVE_BIT = 13;
  localparam int IOH_MASTER_BIT = 12;
  localparam int IOH_ENABLE_BIT = 8;
  localparam int IOH_POLARITY_BIT = 4;
  localparam int IOH_TYPE_BIT = 0;
  localparam logic [7:0] IOH_INTERVAL_RESET = 8'h00;
  localparam int IOH_CLK_MHZ = 100;
  localparam int IOH_TICK_US = 10;
  localparam int IOH_TICK_CYCLES = IOH_TICK_US * IOH_CLK_MHZ;
  typedef enum logic [1:0] {IOH_IDLE, IOH_HOLD} ioh_state_e;
endpackage

// [ioh_tick.sv]
// divider giving one-cycle tick pulse each hold-off unit
module ioh_tick #(
  parameter int CYCLES = ioh_pkg::IOH_TICK_CYCLES
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic clear_in,
  output logic tick_out
);
  import ioh_pkg::*;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic tick_next;
  logic tick_reg;
  always_comb begin
    tick_next = 1'b0;
    cnt_next = cnt_reg + 16'h0001;
    if (clear_in) begin
      cnt_next = 16'h0000;
    end else if (cnt_reg == 16'(CYCLES - 1)) begin
      cnt_next = 16'h0000;
      tick_next = 1'b1;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end
  assign tick_out = tick_reg;
endmodule

// [ioh_pin.sv]
// polarity and buffer-type shaping of the interrupt pin
module ioh_pin (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic assert_in,
  input wire logic pin_polarity_in,
  input wire logic push_pull_in,
  output logic pin_out,
  output logic pin_oe_out
);
  logic pin_reg;
  logic pin_next;
  logic oe_reg;
  logic oe_next;
  always_comb begin
    if (push_pull_in) begin
      pin_next = pin_polarity_in ? assert_in : ~assert_in;
      oe_next = 1'b1;
    end else begin
      // open drain: pull low only when asserted, polarity ignored
      pin_next = 1'b0;
      oe_next = assert_in;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pin_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      pin_reg <= pin_next;
      oe_reg <= oe_next;
    end
  end
  assign pin_out = pin_reg;
  assign pin_oe_out = oe_reg;
endmodule

// [ioh_sva.sv]
// checker for the hold-off interrupt pin and its config register
module ioh_sva #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic source_irq_in,
  input wire logic power_event_in,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] cq_reg, cq_next, cd_reg;
  logic cs, en, act, rd54;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  always_comb begin
    cq_next = cq_reg;
    if (reg_wr_in && reg_addr_in == 8'h54) begin
      cq_next = {reg_wdata_in[31:24], reg_wdata_in[8], reg_wdata_in[4], reg_wdata_in[0]};
    end
  end
  // cd lags one cycle because the pin stage is one register behind the fields
  always_ff @(posedge mclk_in) begin
    cq_reg <= sys_rst_in ? 11'h0 : cq_next;
    cd_reg <= sys_rst_in ? 11'h0 : cq_reg;
  end
  assign cs = cq_reg == cd_reg && !reg_wr_in;
  assign en = cq_reg[2];
  assign act = cd_reg[0] ? irq_pin_out == cd_reg[1] : irq_pin_oe_out;
  assign rd54 = reg_rd_in && reg_addr_in == 8'h54;
  property p_gate; cs && !en |-> !act; endproperty
  a_gate: assert property (p_gate) else $error("pin on while off");
  property p_pol;
    cs && en && cq_reg[0] && power_event_in |=> irq_pin_out == cq_reg[1];
  endproperty
  a_pol: assert property (p_pol) else $error("push-pull level");
  property p_od; cs && en && !cq_reg[0] && power_event_in |=> irq_pin_oe_out; endproperty
  a_od: assert property (p_od) else $error("open-drain level");
  property p_lat; cs && en && cq_reg[10:3] == 8'h0 && source_irq_in |=> ##1 act; endproperty
  a_lat: assert property (p_lat) else $error("irq late");
  property p_hold;
    cs && en && cq_reg[10:3] != 8'h0 && act && $fell(source_irq_in) && !power_event_in
      && TICK_CYCLES > 3 |=> ##1 (!act || $past(power_event_in))[*3];
  endproperty
  a_hold: assert property (p_hold) else $error("hold-off short");
  property p_mst; rd54 |=> reg_rdata_out[12] == $past(source_irq_in || power_event_in); endproperty
  a_mst: assert property (p_mst) else $error("master bit");
  property p_fld;
    rd54 |=> {reg_rdata_out[31:24], reg_rdata_out[8], reg_rdata_out[4], reg_rdata_out[0]}
      == $past(cq_reg);
  endproperty
  a_fld: assert property (p_fld) else $error("field readback");
  property p_rsv;
    reg_rd_in |=> (reg_rdata_out & 32'h00ffceee) == 32'h0
      && ($past(reg_addr_in) == 8'h54 || reg_rdata_out == 32'h0);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
endmodule

// [ioh_host.sv]
// host interrupt input model with board pull-up
module ioh_host (
  input wire logic push_pull_in,
  input wire logic polarity_in,
  input wire logic pin_in,
  input wire logic pin_oe_in,
  output logic active_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lvl;
  assign lvl = push_pull_in ? pin_in : !pin_oe_in;
  assign active_out = push_pull_in ? lvl == polarity_in : !lvl;
endmodule

// [ioh_top_test.sv]
// self-checking bench: register model, host pin model, hold-off timing
module ioh_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic c = 0, r = 1, w = 0, rr = 0, s = 0, pe = 0, pin, oe, act, pp = 0, pol = 0;
  logic [7:0] a = 8'h0;
  logic [31:0] wd = 32'h0, rdo, cfg = 32'h0;
  int err_count = 0, total_checks = 0, cyc = 0;
  always #5 c = ~c;
  ioh_top #(.TICK_CYCLES(4)) dut (.mclk_in(c), .sys_rst_in(r), .reg_addr_in(a),
    .reg_wr_in(w), .reg_rd_in(rr), .reg_wdata_in(wd), .reg_rdata_out(rdo),
    .source_irq_in(s), .power_event_in(pe), .irq_pin_out(pin), .irq_pin_oe_out(oe));
  ioh_host host (.push_pull_in(pp), .polarity_in(pol), .pin_in(pin), .pin_oe_in(oe),
    .active_out(act));
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic e);
    chk({31'h0, act}, {31'h0, e});
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge c);
    #1;
  endtask
  task automatic wr(input logic [31:0] d);
    cfg = d & 32'hff000111;
    tk(1);
    a = 8'h54;
    wd = d;
    w = 1;
    tk(1);
    w = 0;
    pp = d[0];
    pol = d[4];
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    tk(1);
    a = ad;
    rr = 1;
    tk(1);
    rr = 0;
    chk(rdo, e);
  endtask
  always @(posedge c) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    logic [31:0] d;
    void'($urandom(32'hba93));
    tk(12);
    r = 0;
    rd(8'h54, 32'h0);
    rd(8'h58, 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = ($urandom & 32'h00ffbeee) | {23'h0, i[2], 3'h0, i[1], 3'h0, i[0]};
      wr(d);
      rd(8'h54, cfg);
      pe = 1;
      tk(2);
      chk_pin(i[2]);
      rd(8'h54, cfg | 32'h1000);
      pe = 0;
      s = 1;
      tk(3);
      chk_pin(i[2]);
      s = 0;
      tk(2);
      chk_pin(1'b0);
    end
    wr(32'h02000111);
    s = 1;
    tk(3);
    chk_pin(1'b1);
    s = 0;
    tk(3);
    s = 1;
    tk(2);
    chk_pin(1'b0);
    rd(8'h54, 32'h02003111);
    d = 0;
    while (!act && d < 20) begin
      tk(1);
      d++;
    end
    chk_pin(1'b1);
    s = 0;
    tk(6);
    wr(32'h02004111);
    s = 1;
    tk(4);
    chk_pin(1'b0);
    rd(8'h54, 32'h02003111);
    wr(32'h00000111);
    tk(2);
    chk_pin(1'b1);
    rd(8'h54, 32'h00001111);
    s = 0;
    tk(2);
    final_report();
  end
endmodule
bind ioh_top ioh_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.*);
